// file: rot_set_pkg.sv
package rot_set_pkg;

	// ****************************************
	// instruction encoding
	// ****************************************
	localparam logic [5:0] ROT_RIGHT_PREFIX = 6'h10;
	localparam logic [6:0] FILL_ONES_PREFIX = 7'h34;
	localparam int ROT_PREFIX_LSB = 10;
	localparam int FILL_PREFIX_LSB = 9;
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam logic [7:0] FILL_VALUE = 8'hff;

	// ****************************************
	// data memory and access bank
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int MEM_DEPTH = 4096;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// ****************************************
	// status bits
	// ****************************************
	localparam int STAT_N = 4;
	localparam int STAT_Z = 2;
	localparam logic [4:0] STATUS_RESET = 5'h00;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_WREG = 8'h04;
	localparam logic [7:0] OFS_BANK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
	localparam logic [7:0] OFS_MEM_DATA = 8'h18;
	localparam int CTRL_BUSY = 0;
	localparam int CTRL_ILLEGAL = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// instruction cycle phases
	// ****************************************
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_DECODE = 3'h1,
		PH_READ = 3'h3,
		PH_PROCESS = 3'h2,
		PH_WRITE = 3'h6
	} phase_t;

endpackage

// file: rot_set_alu.sv
`timescale 1ns/100ps

// decodes one instruction word and computes the result from the operand
module rot_set_alu
	import rot_set_pkg::*;
(
	// instruction and operand
	input wire logic [15:0] instr,
	input wire logic [7:0] operand,
	input wire logic [3:0] bank_pointer,
	// decode
	output logic rotate_right_plain_op,
	output logic fill_ones_op,
	output logic to_w,
	output logic [ADDR_W-1:0] addr,
	// result
	output logic [7:0] result,
	output logic neg,
	output logic zero
);
	logic [7:0] f;

	always_comb begin
		f = instr[7:0];
		rotate_right_plain_op = (instr[15:ROT_PREFIX_LSB] == ROT_RIGHT_PREFIX);
		fill_ones_op = (instr[15:FILL_PREFIX_LSB] == FILL_ONES_PREFIX);
		// the fill instruction has no destination bit: it always writes the data memory byte
		to_w = rotate_right_plain_op && !instr[DEST_BIT];
		if (instr[ACCESS_BIT]) begin
			addr = {bank_pointer, f};
		end else if (f < ACCESS_SPLIT) begin
			addr = {ACCESS_LOW_BANK, f};
		end else begin
			addr = {ACCESS_HIGH_BANK, f};
		end
		if (fill_ones_op) begin
			result = FILL_VALUE;
		end else begin
			result = {operand[0], operand[7:1]};
		end
		neg = result[7];
		zero = (result == 8'h00);
	end

endmodule

// file: rot_set_core.sv
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps

module rot_set_core
	import rot_set_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	// ****************************************
	// state
	// ****************************************
	logic [7:0] mem [MEM_DEPTH];
	phase_t phase_q, phase_d;
	logic [15:0] instr_q, instr_d;
	logic [7:0] wreg_q, wreg_d;
	logic [3:0] bank_q, bank_d;
	logic [4:0] status_q, status_d;
	logic illegal_q, illegal_d;
	logic [ADDR_W-1:0] mem_addr_q, mem_addr_d;
	logic [7:0] operand_q, operand_d;
	logic [7:0] result_q, result_d;
	// flags are taken with the result, so the write phase needs no second look at it
	logic neg_q, neg_d, zero_q, zero_d;
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	logic rot_op, fill_op, to_w, neg, zero, busy, do_wr, wr_ok;
	logic [ADDR_W-1:0] op_addr;
	logic [7:0] alu_result;
	logic [31:0] wr_old, wr_new, rd_val;
	logic rd_hit, wr_hit;
	logic mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [7:0] mem_wd;

	rot_set_alu u_alu (
		.instr(instr_q),
		.operand(operand_q),
		.bank_pointer(bank_q),
		.rotate_right_plain_op(rot_op),
		.fill_ones_op(fill_op),
		.to_w(to_w),
		.addr(op_addr),
		.result(alu_result),
		.neg(neg),
		.zero(zero)
	);

	assign busy = (phase_q != PH_IDLE);

	// ****************************************
	// register readback
	// ****************************************
	function automatic logic [31:0] reg_value(input logic [7:0] a, output logic hit);
		logic [31:0] v;
		v = 32'h0000_0000;
		hit = 1'b1;
		case (a)
			OFS_INSTR: v = {16'h0000, instr_q};
			OFS_WREG: v = {24'h000000, wreg_q};
			OFS_BANK: v = {28'h0000000, bank_q};
			OFS_STATUS: v = {27'h0, status_q};
			OFS_CTRL: v = {30'h0, illegal_q, busy};
			OFS_MEM_ADDR: v = {20'h00000, mem_addr_q};
			OFS_MEM_DATA: v = {24'h000000, mem[mem_addr_q]};
			// unmapped offsets read as zero and answer with an error
			default: hit = 1'b0;
		endcase
		return v;
	endfunction

	// ****************************************
	// bus channels
	// ****************************************
	assign awready = !aw_hold_q && !bvalid_q;
	assign wready = !w_hold_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	// the answer rises one cycle after both halves are held, together with the register update
	assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;

	always_comb begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d = w_hold_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rd_val = reg_value(araddr, rd_hit);
		wr_old = reg_value(aw_addr_q, wr_hit);
		for (int i = 0; i < 4; i++) begin
			wr_new[i*8 +: 8] = w_strb_q[i] ? w_data_q[i*8 +: 8] : wr_old[i*8 +: 8];
		end
		// writes are refused while an instruction is in flight so that the
		// datapath never races software for the same register or memory byte
		wr_ok = wr_hit && !busy;
		if (awvalid && awready) begin
			aw_hold_d = 1'b1;
			aw_addr_d = {awaddr[7:2], 2'b00};
		end
		if (wvalid && wready) begin
			w_hold_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_val;
			rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_hold_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			aw_addr_q <= aw_addr_d;
			w_hold_q <= w_hold_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************
	// instruction cycle and software registers
	// ****************************************
	always_comb begin
		phase_d = phase_q;
		instr_d = instr_q;
		wreg_d = wreg_q;
		bank_d = bank_q;
		status_d = status_q;
		illegal_d = illegal_q;
		mem_addr_d = mem_addr_q;
		operand_d = operand_q;
		result_d = result_q;
		neg_d = neg_q;
		zero_d = zero_q;
		mem_we = 1'b0;
		mem_wa = op_addr;
		mem_wd = result_q;
		if (do_wr && wr_ok) begin
			case (aw_addr_q)
				OFS_INSTR: begin
					// writing the word starts the cycle at decode; only a known word goes on through all four phases
					instr_d = wr_new[15:0];
					phase_d = PH_DECODE;
				end
				OFS_WREG: wreg_d = wr_new[7:0];
				OFS_BANK: bank_d = wr_new[3:0];
				OFS_STATUS: status_d = wr_new[4:0];
				OFS_MEM_ADDR: mem_addr_d = wr_new[ADDR_W-1:0];
				OFS_MEM_DATA: begin
					mem_we = 1'b1;
					mem_wa = mem_addr_q;
					mem_wd = wr_new[7:0];
				end
				default: ;
			endcase
		end
		case (phase_q)
			PH_IDLE: ;
			PH_DECODE: begin
				// an unknown word ends the cycle at once and touches nothing but the illegal bit
				illegal_d = !(rot_op || fill_op);
				phase_d = (rot_op || fill_op) ? PH_READ : PH_IDLE;
			end
			PH_READ: begin
				operand_d = mem[op_addr];
				phase_d = PH_PROCESS;
			end
			PH_PROCESS: begin
				result_d = alu_result;
				neg_d = neg;
				zero_d = zero;
				phase_d = PH_WRITE;
			end
			PH_WRITE: begin
				if (to_w) begin
					wreg_d = result_q;
				end else begin
					mem_we = 1'b1;
				end
				if (rot_op) begin
					// carry and the remaining flags are kept as they were
					status_d[STAT_N] = neg_q;
					status_d[STAT_Z] = zero_q;
				end
				phase_d = PH_IDLE;
			end
			default: phase_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= PH_IDLE;
			instr_q <= 16'h0000;
			wreg_q <= 8'h00;
			bank_q <= 4'h0;
			status_q <= STATUS_RESET;
			illegal_q <= 1'b0;
			mem_addr_q <= '0;
			operand_q <= 8'h00;
			result_q <= 8'h00;
			neg_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			instr_q <= instr_d;
			wreg_q <= wreg_d;
			bank_q <= bank_d;
			status_q <= status_d;
			illegal_q <= illegal_d;
			mem_addr_q <= mem_addr_d;
			operand_q <= operand_d;
			result_q <= result_d;
			neg_q <= neg_d;
			zero_q <= zero_d;
		end
	end

	// data memory has no reset; software loads it through the memory window
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	logic unused;
	assign unused = ^{awprot, arprot};

endmodule

// file: rot_set_core_monitor.sv
`timescale 1ns/100ps

// ****************************************
// handshake and answer timing checks
// ****************************************
module rot_set_core_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	// read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_r_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_r_cause: assert property ($rose(rvalid) |-> $past(arvalid && arready))
		else $error("read answer without request");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_aw_block: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	// both halves are first held for a cycle, so the answer shows at the second edge
	a_b_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write answer late");
	a_b_code: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
		else $error("bad write code");

	cover property (arvalid && arready);
	cover property (awvalid && awready && wvalid && wready);
	cover property (bvalid && bready && bresp == 2'h2);
endmodule

// file: tb.sv
`timescale 1ns/100ps

module tb
	import rot_set_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [1:0] bresp, rresp, got_resp;
	int fail_count = 0;
	int n_tests = 0;

	rot_set_core u_rot_set_core (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	// ****************************************
	// reporting
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic hang();
		fail_count++;
		$display("BAD %0t wait ran out", $time);
		end_sim();
	endtask

	// ****************************************
	// bus cycles
	// ****************************************
	// ready is raised only once the answer shows, so the slave must hold it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (bvalid && bready) break;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b1;
		end
		if (i == 40) hang();
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er}, "write code");
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (rvalid && rready) break;
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b1;
		end
		if (i == 40) hang();
		rready <= 1'b0;
		got = rdata;
		got_resp = rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
		rd(a);
		chk(got, e, what);
		chk({30'h0, got_resp}, {30'h0, RESP_OKAY}, what);
	endtask

	task automatic poke(input logic [11:0] m, input logic [7:0] v);
		wr(OFS_MEM_ADDR, {20'h0, m}, RESP_OKAY);
		wr(OFS_MEM_DATA, {24'h0, v}, RESP_OKAY);
	endtask

	task automatic peek(input logic [11:0] m, input logic [7:0] v, input string what);
		wr(OFS_MEM_ADDR, {20'h0, m}, RESP_OKAY);
		rchk(OFS_MEM_DATA, {24'h0, v}, what);
	endtask

	task automatic idle();
		int i;
		for (i = 0; i < 20; i++) begin
			rd(OFS_CTRL);
			if (got[CTRL_BUSY] === 1'b0) break;
		end
		if (i == 20) hang();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rchk(OFS_STATUS, 32'h0, "status at reset");
		rchk(OFS_CTRL, 32'h0, "ctrl at reset");
	endtask

	task automatic t_rot_mem();
		poke(12'h010, 8'hd7);
		wr(OFS_STATUS, 32'h1, RESP_OKAY);
		wr(OFS_INSTR, 32'h4210, RESP_OKAY);
		wr(OFS_INSTR, 32'h6810, RESP_SLVERR);
		idle();
		peek(12'h010, 8'heb, "rotate into reg");
		rchk(OFS_STATUS, 32'h11, "rotate flags");
	endtask

	task automatic t_rot_w();
		poke(12'hf90, 8'h00);
		wr(OFS_WREG, 32'h5a, RESP_OKAY);
		wr(OFS_INSTR, 32'h4090, RESP_OKAY);
		idle();
		rchk(OFS_WREG, 32'h0, "rotate into w");
		rchk(OFS_STATUS, 32'h05, "zero flag");
		peek(12'hf90, 8'h00, "source kept");
	endtask

	task automatic t_fill();
		poke(12'h022, 8'h33);
		poke(12'h322, 8'h5a);
		wr(OFS_BANK, 32'h3, RESP_OKAY);
		wr(OFS_STATUS, 32'h0a, RESP_OKAY);
		wr(OFS_INSTR, 32'h6922, RESP_OKAY);
		idle();
		peek(12'h322, 8'hff, "fill");
		peek(12'h022, 8'h33, "other bank kept");
		rchk(OFS_STATUS, 32'h0a, "fill flags");
	endtask

	task automatic t_bad();
		wr(OFS_INSTR, 32'hffff, RESP_OKAY);
		idle();
		rchk(OFS_CTRL, 32'h2, "unknown word");
		rd(8'h1c);
		chk({30'h0, got_resp}, {30'h0, RESP_SLVERR}, "unmapped");
	endtask

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_rot_mem();
		t_rot_w();
		t_fill();
		t_bad();
		end_sim();
	end
endmodule

bind rot_set_core rot_set_core_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata));
